// ==== core/dual_channel_config_regs.sv ====
// Register bank of a dual-channel converter with shadowed program registers.
// Assumes a serial port front end that presents one decoded byte access per pulse.
module dual_channel_config_regs
    import config_regs_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              resetn,
    input  wire logic              regWrite,
    input  wire logic              regRead,
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [DATA_W-1:0] regWdata,
    output logic      [DATA_W-1:0] regRdata,
    output logic                   lsbFirst,
    output logic                   softResetPulse,
    output logic      [DATA_W-1:0] modesChanA,
    output logic      [DATA_W-1:0] modesChanB,
    output logic                   dutyStabilizer,
    output logic      [2:0]        clockDivCode,
    output logic                   dividedClockTick
);
    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers
    function automatic logic inShadowRange(input logic [ADDR_W-1:0] a);
        return (a >= SHADOW_LO) && (a <= SHADOW_HI);
    endfunction

    function automatic logic hitWrite(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] target);
        return regWrite && (a == target);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State
    logic [7:0] portSetup_reg,  portSetup_next;
    logic [7:0] chanSel_reg,    chanSel_next;
    logic [7:0] commit_reg,     commit_next;
    logic [7:0] shModes_reg [2];
    logic [7:0] shModes_next [2];
    logic [7:0] actModes_reg [2];
    logic [7:0] actModes_next [2];
    logic [7:0] shClkOpt_reg,   shClkOpt_next;
    logic [7:0] actClkOpt_reg,  actClkOpt_next;
    logic [7:0] shClkDiv_reg,   shClkDiv_next;
    logic [7:0] actClkDiv_reg,  actClkDiv_next;
    logic [7:0] rdata_reg,      rdata_next;
    logic       srst_reg,       srst_next;
    logic       srstReq;
    logic       commitNow;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        portSetup_next = portSetup_reg;
        chanSel_next   = chanSel_reg;
        commit_next    = commit_reg;
        shClkOpt_next  = shClkOpt_reg;
        actClkOpt_next = actClkOpt_reg;
        shClkDiv_next  = shClkDiv_reg;
        actClkDiv_next = actClkDiv_reg;
        for (int c = 0; c < 2; c++) begin
            shModes_next[c]  = shModes_reg[c];
            actModes_next[c] = actModes_reg[c];
        end

        // Soft reset requested from either mirrored position
        srstReq = hitWrite(regAddr, ADDR_PORT_SETUP)
                  && (regWdata[BIT_SRST_LO] || regWdata[BIT_SRST_HI]);
        srst_next = srstReq;
        commitNow = commit_reg[0];

        if (srst_reg) begin
            // Soft reset restores every default and leaves its own bits clear
            portSetup_next = RST_PORT_SETUP;
            chanSel_next   = RST_CHAN_SEL;
            commit_next    = RST_COMMIT;
            shClkOpt_next  = RST_CLK_OPT;
            actClkOpt_next = RST_CLK_OPT;
            shClkDiv_next  = RST_CLK_DIV;
            actClkDiv_next = RST_CLK_DIV;
            for (int c = 0; c < 2; c++) begin
                shModes_next[c]  = RST_MODES;
                actModes_next[c] = RST_MODES;
            end
        end else begin
            if (hitWrite(regAddr, ADDR_PORT_SETUP)) begin
                // Order bit honoured from either nibble; soft reset bits never stored
                portSetup_next = PORT_FIXED;
                portSetup_next[BIT_LSB_LO] = regWdata[BIT_LSB_LO] | regWdata[BIT_LSB_HI];
                portSetup_next[BIT_LSB_HI] = regWdata[BIT_LSB_LO] | regWdata[BIT_LSB_HI];
            end
            if (hitWrite(regAddr, ADDR_CHAN_SEL))
                chanSel_next = regWdata & CHAN_SEL_MASK;
            // Global shadow registers ignore channel select
            if (hitWrite(regAddr, ADDR_CLK_OPT) && inShadowRange(regAddr))
                shClkOpt_next = regWdata & CLK_OPT_MASK;
            if (hitWrite(regAddr, ADDR_CLK_DIV) && inShadowRange(regAddr))
                shClkDiv_next = regWdata & CLK_DIV_MASK;
            for (int c = 0; c < 2; c++) begin
                if (hitWrite(regAddr, ADDR_MODES) && chanSel_reg[c])
                    shModes_next[c] = regWdata;
            end
            // Commit: every shadow moves to its active copy in one edge
            if (commitNow) begin
                actClkOpt_next = shClkOpt_reg;
                actClkDiv_next = shClkDiv_reg;
                for (int c = 0; c < 2; c++)
                    actModes_next[c] = shModes_reg[c];
                commit_next = RST_COMMIT;
            end
            if (hitWrite(regAddr, ADDR_COMMIT))
                commit_next = regWdata & COMMIT_CODE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data
    always_comb begin
        rdata_next = rdata_reg;
        if (regRead) begin
            case (regAddr)
                ADDR_PORT_SETUP: rdata_next = portSetup_reg;
                ADDR_PART_ID:    rdata_next = PART_ID_VALUE;
                ADDR_GRADE:      rdata_next = GRADE_VALUE;
                ADDR_CHAN_SEL:   rdata_next = chanSel_reg;
                // Channel A wins when both are selected
                ADDR_MODES:      rdata_next = chanSel_reg[CH_A_BIT] ? shModes_reg[0] :
                                              chanSel_reg[CH_B_BIT] ? shModes_reg[1] : shModes_reg[0];
                ADDR_CLK_OPT:    rdata_next = shClkOpt_reg;
                ADDR_CLK_DIV:    rdata_next = shClkDiv_reg;
                ADDR_COMMIT:     rdata_next = commit_reg;
                default:         rdata_next = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            portSetup_reg <= RST_PORT_SETUP;
            chanSel_reg   <= RST_CHAN_SEL;
            commit_reg    <= RST_COMMIT;
            shClkOpt_reg  <= RST_CLK_OPT;
            actClkOpt_reg <= RST_CLK_OPT;
            shClkDiv_reg  <= RST_CLK_DIV;
            actClkDiv_reg <= RST_CLK_DIV;
            rdata_reg     <= 8'h00;
            srst_reg      <= 1'b0;
            for (int c = 0; c < 2; c++) begin
                shModes_reg[c]  <= RST_MODES;
                actModes_reg[c] <= RST_MODES;
            end
        end else begin
            portSetup_reg <= portSetup_next;
            chanSel_reg   <= chanSel_next;
            commit_reg    <= commit_next;
            shClkOpt_reg  <= shClkOpt_next;
            actClkOpt_reg <= actClkOpt_next;
            shClkDiv_reg  <= shClkDiv_next;
            actClkDiv_reg <= actClkDiv_next;
            rdata_reg     <= rdata_next;
            srst_reg      <= srst_next;
            for (int c = 0; c < 2; c++) begin
                shModes_reg[c]  <= shModes_next[c];
                actModes_reg[c] <= actModes_next[c];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign regRdata       = rdata_reg;
    assign lsbFirst       = portSetup_reg[BIT_LSB_LO];
    assign softResetPulse = srst_reg;
    assign modesChanA     = actModes_reg[0];
    assign modesChanB     = actModes_reg[1];
    assign dutyStabilizer = actClkOpt_reg[0];
    assign clockDivCode   = actClkDiv_reg[2:0];

    clock_divider #(
        .CODE_W (3)
    ) u_clock_divider (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .divCode (actClkDiv_reg[2:0]),
        .divTick (dividedClockTick)
    );
endmodule

// ==== shared/config_regs_pkg.sv ====
// Constants of the dual-channel configuration register bank.
// Assumes a byte-wide register access strobe already decoded from the serial port.
package config_regs_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 8;
    localparam logic [7:0]  ADDR_PORT_SETUP = 8'h00;
    localparam logic [7:0]  ADDR_PART_ID    = 8'h01;
    localparam logic [7:0]  ADDR_GRADE      = 8'h02;
    localparam logic [7:0]  ADDR_CHAN_SEL   = 8'h05;
    localparam logic [7:0]  ADDR_MODES      = 8'h08;
    localparam logic [7:0]  ADDR_CLK_OPT    = 8'h09;
    localparam logic [7:0]  ADDR_CLK_DIV    = 8'h0b;
    localparam logic [7:0]  ADDR_COMMIT     = 8'hff;
    localparam logic [7:0]  SHADOW_LO       = 8'h08;
    localparam logic [7:0]  SHADOW_HI       = 8'h18;
    localparam logic [7:0]  RST_PORT_SETUP  = 8'h18;
    localparam logic [7:0]  RST_CHAN_SEL    = 8'h03;
    localparam logic [7:0]  RST_MODES       = 8'h80;
    localparam logic [7:0]  RST_CLK_OPT     = 8'h00;
    localparam logic [7:0]  RST_CLK_DIV     = 8'h00;
    localparam logic [7:0]  RST_COMMIT      = 8'h00;
    localparam logic [7:0]  COMMIT_CODE     = 8'h01;
    localparam logic [7:0]  PORT_FIXED      = 8'h18;
    localparam int          BIT_LSB_LO      = 1;
    localparam int          BIT_LSB_HI      = 6;
    localparam int          BIT_SRST_LO     = 2;
    localparam int          BIT_SRST_HI     = 5;
    localparam int          CH_A_BIT        = 0;
    localparam int          CH_B_BIT        = 1;
    localparam logic [7:0]  CHAN_SEL_MASK   = 8'h03;
    localparam logic [7:0]  CLK_OPT_MASK    = 8'h01;
    localparam logic [7:0]  CLK_DIV_MASK    = 8'h07;
    localparam logic [2:0]  DIV_MAX_CODE    = 3'h5;
    localparam logic [7:0]  PART_ID_VALUE   = 8'h5a; // Arbitrary value
    localparam logic [7:0]  GRADE_VALUE     = 8'h00; // Arbitrary value
endpackage

// ==== core/clock_divider.sv ====
// Integer input clock divider, ratio = code + 1, up to a ratio of 6.
// Assumes the code only changes on a committed update.
module clock_divider
    import config_regs_pkg::*;
#(
    parameter int CODE_W = 3
) (
    input  wire logic              clk_sys,
    input  wire logic              resetn,
    input  wire logic [CODE_W-1:0] divCode,
    output logic                   divTick
);
    logic [CODE_W-1:0] count_reg;
    logic [CODE_W-1:0] count_next;
    logic              tick_reg;
    logic              tick_next;
    logic [CODE_W-1:0] limit;

    always_comb begin
        // Codes above the top ratio saturate at it
        limit      = (divCode > DIV_MAX_CODE) ? DIV_MAX_CODE : divCode;
        tick_next  = (count_reg >= limit);
        count_next = tick_next ? '0 : CODE_W'(count_reg + 1'b1);
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            count_reg <= '0;
            tick_reg  <= 1'b0;
        end else begin
            count_reg <= count_next;
            tick_reg  <= tick_next;
        end
    end

    assign divTick = tick_reg;
endmodule

// ==== tb/dual_channel_config_regs_properties.sv ====
// Checker of port relations of the register bank.
// Assumes it is bound to the register bank top module.
module config_regs_checker
    import config_regs_pkg::*;
(
    input wire logic              clk_sys,
    input wire logic              resetn,
    input wire logic              regWrite,
    input wire logic              regRead,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic [DATA_W-1:0] regRdata,
    input wire logic              lsbFirst,
    input wire logic              softResetPulse,
    input wire logic [DATA_W-1:0] modesChanA,
    input wire logic [DATA_W-1:0] modesChanB,
    input wire logic              dutyStabilizer,
    input wire logic [2:0]        clockDivCode,
    input wire logic              dividedClockTick
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////
    property p_shadow_hold;
        regWrite && regAddr == ADDR_MODES && !softResetPulse && !$past(regWrite && regAddr == ADDR_COMMIT)
        |=> $stable(modesChanA) && $stable(modesChanB);
    endproperty
    a_shadow_hold: assert property (p_shadow_hold) else $error("Active modes moved on a shadow write");
    property p_commit_only;
        $changed(modesChanA) || $changed(modesChanB) || $changed(clockDivCode)
        |-> $past(regWrite && regAddr == ADDR_COMMIT && regWdata[0], 2) || $past(softResetPulse);
    endproperty
    a_commit_only: assert property (p_commit_only) else $error("Active copy changed without commit");
    property p_reset_defaults;
        $rose(resetn) |-> modesChanA == RST_MODES && modesChanB == RST_MODES && clockDivCode == 3'h0 && !lsbFirst;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults) else $error("Defaults wrong after reset");
    property p_soft_defaults;
        softResetPulse |=> modesChanA == RST_MODES && modesChanB == RST_MODES && clockDivCode == 3'h0 && !lsbFirst;
    endproperty
    a_soft_defaults: assert property (p_soft_defaults) else $error("Defaults wrong after soft reset");
    property p_div_six;
        dividedClockTick && clockDivCode == 3'h5 |=> (!dividedClockTick || clockDivCode != 3'h5) [*5]
        ##1 (dividedClockTick || clockDivCode != 3'h5);
    endproperty
    a_div_six: assert property (p_div_six) else $error("Tick spacing wrong for code five");
    property p_soft_pulse;
        regWrite && regAddr == ADDR_PORT_SETUP && !softResetPulse && (regWdata[BIT_SRST_LO] || regWdata[BIT_SRST_HI])
        |=> softResetPulse ##1 !softResetPulse;
    endproperty
    a_soft_pulse: assert property (p_soft_pulse) else $error("Soft reset pulse missing");
    property p_lsb_mirror;
        regWrite && regAddr == ADDR_PORT_SETUP && !softResetPulse && !regWdata[BIT_SRST_LO] && !regWdata[BIT_SRST_HI]
        |=> lsbFirst == ($past(regWdata[BIT_LSB_LO]) || $past(regWdata[BIT_LSB_HI]));
    endproperty
    a_lsb_mirror: assert property (p_lsb_mirror) else $error("Bit order not taken from mirror");
    property p_part_id;
        regRead && regAddr == ADDR_PART_ID && !softResetPulse |=> regRdata == PART_ID_VALUE;
    endproperty
    a_part_id: assert property (p_part_id) else $error("Part identifier read wrong");
endmodule
bind dual_channel_config_regs config_regs_checker checker_u (
    .clk_sys          (clk_sys),
    .resetn           (resetn),
    .regWrite         (regWrite),
    .regRead          (regRead),
    .regAddr          (regAddr),
    .regWdata         (regWdata),
    .regRdata         (regRdata),
    .lsbFirst         (lsbFirst),
    .softResetPulse   (softResetPulse),
    .modesChanA       (modesChanA),
    .modesChanB       (modesChanB),
    .dutyStabilizer   (dutyStabilizer),
    .clockDivCode     (clockDivCode),
    .dividedClockTick (dividedClockTick)
);

// ==== tb/host_port_model.sv ====
// Host model issuing single byte register accesses.
// Assumes strobes are sampled on the rising clock edge.
module host_port_model
    import config_regs_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic [DATA_W-1:0] regRdata,
    output logic                   regWrite = 1'b0,
    output logic                   regRead  = 1'b0,
    output logic      [ADDR_W-1:0] regAddr  = 8'h00,
    output logic      [DATA_W-1:0] regWdata = 8'h00
);
    // Callers give unused bits as zero and never write open addresses
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk_sys);
        regWrite <= 1'b0;
        regAddr <= ~a;
        regWdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRead <= 1'b0;
        regAddr <= ~a;
        @(negedge clk_sys);
        d = regRdata;
    endtask
endmodule

// ==== tb/dual_channel_config_regs_tb_top.sv ====
// Self-checking bench of the register bank.
// Assumes the host model and the checker are compiled first.
`define CHK(n, e, s) begin testsRun++; if ((s) !== (e)) begin failCount++; \
    $display("MISMATCH %s expected %h seen %h", n, e, s); end end
module dual_channel_config_regs_tb_top
    import config_regs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0;
    logic resetn  = 1'b0;
    logic regWrite, regRead, lsbFirst, softResetPulse, dutyStabilizer, dividedClockTick;
    logic [7:0] regAddr, regWdata, regRdata, modesChanA, modesChanB, v;
    logic [2:0] clockDivCode;
    int failCount = 0;
    int testsRun  = 0;
    int ticks     = 0;
    logic [7:0] dA [9] = '{ADDR_PORT_SETUP, ADDR_PART_ID, ADDR_GRADE, ADDR_CHAN_SEL, ADDR_MODES, ADDR_CLK_OPT,
                           ADDR_CLK_DIV, ADDR_COMMIT, 8'h13};
    logic [7:0] dV [9] = '{RST_PORT_SETUP, PART_ID_VALUE, GRADE_VALUE, RST_CHAN_SEL, RST_MODES, RST_CLK_OPT,
                           RST_CLK_DIV, RST_COMMIT, 8'h00};
    dual_channel_config_regs DUT (
        .clk_sys          (clk_sys),
        .resetn           (resetn),
        .regWrite         (regWrite),
        .regRead          (regRead),
        .regAddr          (regAddr),
        .regWdata         (regWdata),
        .regRdata         (regRdata),
        .lsbFirst         (lsbFirst),
        .softResetPulse   (softResetPulse),
        .modesChanA       (modesChanA),
        .modesChanB       (modesChanB),
        .dutyStabilizer   (dutyStabilizer),
        .clockDivCode     (clockDivCode),
        .dividedClockTick (dividedClockTick)
    );
    host_port_model HOST (
        .clk_sys  (clk_sys),
        .regRdata (regRdata),
        .regWrite (regWrite),
        .regRead  (regRead),
        .regAddr  (regAddr),
        .regWdata (regWdata)
    );
    always #50 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////
    task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
        HOST.rd(a, v);
        `CHK($sformatf("reg %h", a), e, v)
    endtask
    task automatic commit();
        HOST.wr(ADDR_COMMIT, COMMIT_CODE);
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task automatic closeOut();
        $display("Comparisons %0d mismatches %0d", testsRun, failCount);
        if (failCount == 0 && testsRun > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Limit well above the fewer than two hundred cycles the sequence needs
    initial begin
        #300000;
        failCount++;
        closeOut();
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        resetn <= 1'b1;
        foreach (dA[i]) rdChk(dA[i], dV[i]);
        HOST.wr(ADDR_CHAN_SEL, 8'h02);
        HOST.wr(ADDR_MODES, 8'h44);
        HOST.wr(ADDR_CHAN_SEL, 8'h01);
        HOST.wr(ADDR_MODES, 8'h12);
        HOST.wr(ADDR_CLK_DIV, 8'h05);
        HOST.wr(ADDR_CLK_OPT, 8'h01);
        @(negedge clk_sys);
        `CHK("modesA", RST_MODES, modesChanA)
        `CHK("modesB", RST_MODES, modesChanB)
        `CHK("divCode", 3'h0, clockDivCode)
        rdChk(ADDR_CLK_DIV, 8'h05);
        HOST.wr(ADDR_CHAN_SEL, 8'h03);
        rdChk(ADDR_MODES, 8'h12);
        commit();
        `CHK("modesA", 8'h12, modesChanA)
        `CHK("modesB", 8'h44, modesChanB)
        `CHK("divCode", 3'h5, clockDivCode)
        `CHK("dutyStab", 1'b1, dutyStabilizer)
        rdChk(ADDR_COMMIT, 8'h00);
        HOST.wr(ADDR_MODES, 8'h21);
        commit();
        `CHK("modesAB", 16'h2121, {modesChanA, modesChanB})
        repeat (60) @(negedge clk_sys) if (dividedClockTick === 1'b1) ticks++;
        `CHK("ticks", 10, ticks)
        HOST.wr(ADDR_PORT_SETUP, 8'h02);
        rdChk(ADDR_PORT_SETUP, PORT_FIXED | 8'h42);
        `CHK("lsbFirst", 1'b1, lsbFirst)
        HOST.wr(ADDR_PORT_SETUP, 8'h00);
        rdChk(ADDR_PORT_SETUP, PORT_FIXED);
        `CHK("lsbFirst", 1'b0, lsbFirst)
        HOST.wr(ADDR_PORT_SETUP, 8'h40);
        rdChk(ADDR_PORT_SETUP, PORT_FIXED | 8'h42);
        `CHK("lsbFirst", 1'b1, lsbFirst)
        HOST.wr(ADDR_CHAN_SEL, 8'h01);
        HOST.wr(ADDR_PORT_SETUP, 8'h44);
        rdChk(ADDR_PORT_SETUP, RST_PORT_SETUP);
        `CHK("lsbFirst", 1'b0, lsbFirst)
        `CHK("modesA", RST_MODES, modesChanA)
        `CHK("divCode", 3'h0, clockDivCode)
        rdChk(ADDR_CHAN_SEL, RST_CHAN_SEL);
        HOST.wr(ADDR_CHAN_SEL, 8'h02);
        HOST.wr(ADDR_MODES, 8'h33);
        commit();
        `CHK("modesAB", 16'h8033, {modesChanA, modesChanB})
        @(posedge clk_sys);
        resetn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        @(negedge clk_sys);
        `CHK("modesB", RST_MODES, modesChanB)
        rdChk(ADDR_CHAN_SEL, RST_CHAN_SEL);
        closeOut();
    end
endmodule
